// [rtl/flash_link_if.sv]
// Serial link between the flash device end and its host controller.
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so);
endinterface : flash_link_if

// [rtl/flash_page_dev.sv]
// Device end: command decode, page-buffer operation sequencing and status read-out.
module flash_page_dev
  import flash_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Serial link.
  flash_link_if.dev LINK,
  // Configuration and status inputs.
  input wire logic PAGE_BINARY,
  input wire logic PROTECT_ON,
  input wire logic ERASE_PROGRAM_FAIL,
  input wire logic LOCKDOWN_CMD_ENABLED,
  input wire logic BUF_ONE_PROG_SUSPENDED,
  input wire logic BUF_TWO_PROG_SUSPENDED,
  input wire logic ERASE_SUSPENDED,
  // Array operation handshake.
  output logic OP_START,
  output op_kind_t OP_KIND,
  output logic OP_BUF,
  output logic [PAGE_W-1:0] OP_PAGE,
  input wire logic OP_DONE,
  input wire logic OP_MISMATCH,
  output logic READY
);
  // ---------------------------------------------------------------
  // Link synchronisers and edge detection.
  // ---------------------------------------------------------------
  logic [1:0] sck_s_r;
  logic [1:0] csn_s_r;
  logic [1:0] si_s_r;
  logic sck_d_r;
  logic csn_d_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_low;
  logic cs_rise;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sck_s_r <= 2'h0;
      csn_s_r <= 2'h3;
      si_s_r <= 2'h0;
      sck_d_r <= 1'b0;
      csn_d_r <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[0], LINK.sck};
      csn_s_r <= {csn_s_r[0], LINK.cs_n};
      si_s_r <= {si_s_r[0], LINK.si};
      sck_d_r <= sck_s_r[1];
      csn_d_r <= csn_s_r[1];
    end
  end

  assign sck_rise = sck_s_r[1] & ~sck_d_r;
  assign sck_fall = ~sck_s_r[1] & sck_d_r;
  assign cs_low = ~csn_s_r[1];
  assign cs_rise = csn_s_r[1] & ~csn_d_r;

  // ---------------------------------------------------------------
  // Command shift register.
  // ---------------------------------------------------------------
  logic [CMD_BITS-1:0] sh_r;
  logic [5:0] bit_cnt_r;

  // Bits past the address are ignored; the counter saturates.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !cs_low) begin
      bit_cnt_r <= 6'h0;
    end else if (sck_rise && bit_cnt_r != 6'(CMD_BITS)) begin
      bit_cnt_r <= bit_cnt_r + 6'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sh_r <= '0;
    end else if (cs_low && sck_rise && bit_cnt_r != 6'(CMD_BITS)) begin
      sh_r <= {sh_r[CMD_BITS-2:0], si_s_r[1]};
    end
  end

  // Returns {valid, kind, buffer select} for a page-buffer opcode.
  function automatic logic [3:0] decode_op(input logic [7:0] opc);
    case (opc)
      OP_XFER_B1: decode_op = {1'b1, KIND_XFER, 1'b0};
      OP_XFER_B2: decode_op = {1'b1, KIND_XFER, 1'b1};
      OP_COMP_B1: decode_op = {1'b1, KIND_COMP, 1'b0};
      OP_COMP_B2: decode_op = {1'b1, KIND_COMP, 1'b1};
      OP_RWR_B1: decode_op = {1'b1, KIND_XFER, 1'b0};
      OP_RWR_B2: decode_op = {1'b1, KIND_XFER, 1'b1};
      default: decode_op = 4'h0;
    endcase
  endfunction : decode_op

  logic [3:0] dec;
  logic is_rewrite;
  logic [PAGE_W-1:0] page_idx;
  logic launch;

  assign dec = decode_op(sh_r[CMD_BITS-1 -: OPC_BITS]);
  assign is_rewrite = sh_r[CMD_BITS-1 -: OPC_BITS] == OP_RWR_B1 ||
                      sh_r[CMD_BITS-1 -: OPC_BITS] == OP_RWR_B2;
  assign page_idx = PAGE_BINARY ? sh_r[PAGE_LSB_BIN +: PAGE_W] :
                                  sh_r[PAGE_LSB_STD +: PAGE_W];
  // A full command is launched at chip select rising; busy drops it.
  assign launch = cs_rise && bit_cnt_r == 6'(CMD_BITS) && dec[3] && READY;

  // ---------------------------------------------------------------
  // Operation sequencer.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } op_state_t;

  op_state_t state_r;
  logic rewrite_r;
  logic comp_r;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_r <= ST_IDLE;
      READY <= 1'b1;
      OP_START <= 1'b0;
      OP_KIND <= KIND_XFER;
      OP_BUF <= 1'b0;
      OP_PAGE <= '0;
      rewrite_r <= 1'b0;
      comp_r <= 1'b0;
    end else begin
      OP_START <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            OP_START <= 1'b1;
            OP_KIND <= op_kind_t'(dec[2:1]);
            OP_BUF <= dec[0];
            OP_PAGE <= page_idx;
            rewrite_r <= is_rewrite;
            READY <= 1'b0;
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (OP_DONE && !OP_START) begin
            if (OP_KIND == KIND_COMP) begin
              comp_r <= OP_MISMATCH;
            end
            if (rewrite_r && OP_KIND == KIND_XFER) begin
              OP_KIND <= KIND_PROG;
              OP_START <= 1'b1;
            end else begin
              READY <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
          READY <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status read-out.
  // ---------------------------------------------------------------
  logic [7:0] stat_one;
  logic [7:0] stat_two;
  logic [7:0] stat_cur;
  logic stat_mode_r;
  logic [2:0] stat_bit_r;
  logic stat_sel_r;
  logic [6:0] stat_sh_r;
  logic so_r;
  logic so_oe_r;

  assign stat_one = {READY, comp_r, DENSITY_CODE, PROTECT_ON, PAGE_BINARY};
  assign stat_two = {READY, 1'b0, ERASE_PROGRAM_FAIL, 1'b0, LOCKDOWN_CMD_ENABLED,
                     BUF_TWO_PROG_SUSPENDED, BUF_ONE_PROG_SUSPENDED, ERASE_SUSPENDED};
  assign stat_cur = stat_sel_r ? stat_two : stat_one;

  // Status mode does not depend on the sequencer, so it works while busy.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !cs_low) begin
      stat_mode_r <= 1'b0;
    end else if (bit_cnt_r == 6'(OPC_BITS) && sh_r[OPC_BITS-1:0] == OP_STATUS) begin
      stat_mode_r <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !cs_low) begin
      stat_bit_r <= 3'h0;
      stat_sel_r <= 1'b0;
      stat_sh_r <= 7'h0;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (stat_mode_r && sck_fall) begin
      so_oe_r <= 1'b1;
      stat_bit_r <= stat_bit_r + 3'h1;
      if (stat_bit_r == 3'h0) begin
        so_r <= stat_cur[7];
        stat_sh_r <= stat_cur[6:0];
      end else begin
        so_r <= stat_sh_r[6];
        stat_sh_r <= {stat_sh_r[5:0], 1'b0};
      end
      if (stat_bit_r == 3'h7) begin
        stat_sel_r <= ~stat_sel_r;
      end
    end
  end

  assign LINK.so = so_r;
  assign LINK.so_oe = so_oe_r;
endmodule : flash_page_dev

// [rtl/flash_page_host.sv]
// Host end: AHB-Lite command registers driving the serial link.
module flash_page_host
  import flash_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Serial link.
  flash_link_if.host LINK
);
  // ---------------------------------------------------------------
  // Bus slave with one wait state on every transfer.
  // ---------------------------------------------------------------
  logic ph_r;
  logic ph_wr_r;
  logic [7:0] ph_addr_r;
  logic [23:0] addr_r;
  logic busy_r;
  logic [15:0] rx_r;
  logic go;

  // The slave never signals an error, so the response stays OKAY.
  always_ff @(posedge SYS_CLK) begin
    HRESP <= 1'b0;
  end

  assign go = ph_r && ph_wr_r && ph_addr_r == REG_CTRL && !busy_r;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ph_r <= 1'b0;
      ph_wr_r <= 1'b0;
      ph_addr_r <= 8'h0;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h0;
      addr_r <= 24'h0;
    end else if (ph_r) begin
      ph_r <= 1'b0;
      HREADYOUT <= 1'b1;
      if (ph_wr_r && ph_addr_r == REG_ADDR) begin
        addr_r <= HWDATA[23:0];
      end
      case (ph_addr_r)
        REG_ADDR: HRDATA <= {8'h0, addr_r};
        REG_STAT: HRDATA <= {8'h0, rx_r, 7'h0, busy_r};
        default: HRDATA <= 32'h0;
      endcase
    end else if (HSEL && HTRANS[1] && HREADY) begin
      ph_r <= 1'b1;
      ph_wr_r <= HWRITE;
      ph_addr_r <= HADDR[7:0];
      HREADYOUT <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Serial engine, SPI mode 0.
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW = 4'b0010,
    H_HIGH = 4'b0100,
    H_GAP = 4'b1000
  } host_state_t;

  host_state_t hst_r;
  logic [1:0] so_s_r;
  logic [31:0] tx_r;
  logic [5:0] cnt_r;
  logic [4:0] div_r;
  logic stat_r;
  logic poll_r;
  logic cs_n_r;
  logic sck_r;
  logic byte_end;
  logic last_bit;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      so_s_r <= 2'h0;
    end else begin
      so_s_r <= {so_s_r[0], LINK.so};
    end
  end

  assign byte_end = cnt_r[2:0] == 3'h7 && cnt_r >= 6'(OPC_BITS);
  assign last_bit = stat_r ? (byte_end && (poll_r ? rx_r[7] : cnt_r == 6'(STAT_BITS - 1)))
                           : cnt_r == 6'(CMD_BITS - 1);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      hst_r <= H_IDLE;
      busy_r <= 1'b0;
      cs_n_r <= 1'b1;
      sck_r <= 1'b0;
      tx_r <= 32'h0;
      cnt_r <= 6'h0;
      div_r <= 5'h0;
      stat_r <= 1'b0;
      poll_r <= 1'b0;
      rx_r <= 16'h0;
    end else begin
      case (hst_r)
        H_IDLE: begin
          if (go) begin
            busy_r <= 1'b1;
            cs_n_r <= 1'b0;
            stat_r <= HWDATA[7:0] == OP_STATUS;
            poll_r <= HWDATA[CTRL_POLL_BIT];
            tx_r <= {HWDATA[7:0], addr_r};
            cnt_r <= 6'h0;
            div_r <= 5'h0;
            hst_r <= H_LOW;
          end
        end
        H_LOW: begin
          div_r <= div_r + 5'h1;
          if (div_r == 5'(SCK_HALF_CYC - 1)) begin
            div_r <= 5'h0;
            sck_r <= 1'b1;
            if (stat_r && cnt_r >= 6'(OPC_BITS)) begin
              rx_r <= {rx_r[14:0], so_s_r[1]};
            end
            hst_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          div_r <= div_r + 5'h1;
          if (div_r == 5'(SCK_HALF_CYC - 1)) begin
            div_r <= 5'h0;
            sck_r <= 1'b0;
            tx_r <= {tx_r[30:0], 1'b0};
            if (last_bit) begin
              cs_n_r <= 1'b1;
              hst_r <= H_GAP;
            end else begin
              cnt_r <= (stat_r && cnt_r == 6'(STAT_BITS - 1)) ? 6'(OPC_BITS) : cnt_r + 6'h1;
              hst_r <= H_LOW;
            end
          end
        end
        H_GAP: begin
          div_r <= div_r + 5'h1;
          if (div_r == 5'(CS_GAP_CYC - 1)) begin
            busy_r <= 1'b0;
            hst_r <= H_IDLE;
          end
        end
        default: begin
          hst_r <= H_IDLE;
          cs_n_r <= 1'b1;
          sck_r <= 1'b0;
        end
      endcase
    end
  end

  assign LINK.cs_n = cs_n_r;
  assign LINK.sck = sck_r;
  assign LINK.si = tx_r[31];
endmodule : flash_page_host

// [rtl/flash_pkg.sv]
// Shared constants and types for the serial flash page-buffer command link.
//
// Behaviour
// - Transfer opcodes 53h, 55h plus three address bytes.
// - 528 mode: 2 dummy, 12 page, 10 dummy.
// - 512 mode: 3 dummy, page BINARY_PAGE_INDEX, 9 dummy.
// - Host holds chip select low while clocking.
// - Transfer starts on chip select rising.
// - Ready flag shows busy during transfer.
// - Compare opcodes 60h, 61h plus three address bytes.
// - Compare on chip select rising, busy meanwhile.
// - Compare result in byte one bit 6.
// - Rewrite opcodes 58h, 59h plus three address bytes.
// - Rewrite copies then programs back, busy throughout.
// - Host refreshes sector pages within 20,000 operations; the host end does not count operations or issue refreshes.
// - Opcode D7h then status on every clock.
// - Status read accepted at any time.
// - Status wraps from byte two to one.
// - Status sampled live for every byte.
// - Chip select high ends read, output released.
// - Byte one bit 7 is ready flag.
// - Byte one bit 1 is sector protection.
// - Byte one bit 0 is page size.
// - Byte two carries ready, fail, lockdown, suspends.
// - Host polls status until ready rises.
package flash_pkg;
  // ---------------------------------------------------------------
  // Opcodes.
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_XFER_B1 = 8'h53;
  localparam logic [7:0] OP_XFER_B2 = 8'h55;
  localparam logic [7:0] OP_COMP_B1 = 8'h60;
  localparam logic [7:0] OP_COMP_B2 = 8'h61;
  localparam logic [7:0] OP_RWR_B1 = 8'h58;
  localparam logic [7:0] OP_RWR_B2 = 8'h59;
  localparam logic [7:0] OP_STATUS = 8'hd7;
  // ---------------------------------------------------------------
  // Frame layout.
  // ---------------------------------------------------------------
  localparam int CMD_BITS = 32;
  localparam int OPC_BITS = 8;
  localparam int STAT_BITS = 24;
  localparam int PAGE_W = 12;
  localparam int PAGE_LSB_STD = 10;
  localparam int PAGE_LSB_BIN = 9;
  // Density code value is arbitrary.
  localparam logic [3:0] DENSITY_CODE = 4'h5;
  // ---------------------------------------------------------------
  // Host timing and registers.
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_NS = 50;
  localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CTRL_POLL_BIT = 8;
  // ---------------------------------------------------------------
  // Internal operation kinds.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_XFER = 2'h0,
    KIND_COMP = 2'h1,
    KIND_PROG = 2'h2
  } op_kind_t;
endpackage : flash_pkg

// [sim/flash_page_link_assertions.sv]
// Protocol checks on the serial link between host and device ends.
module flash_page_link_assertions (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Link signals.
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic [5:0] rise_cnt_r;
  always_ff @(posedge SYS_CLK) begin
    sck_q <= SYS_RST ? 1'b0 : sck;
  end
  // Counts serial clock rises within the current frame.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || cs_n) begin
      rise_cnt_r <= 6'h00;
    end else if (sck && !sck_q && rise_cnt_r != 6'h3f) begin
      rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock active while deselected");
  property p_sck_phase; $rose(sck) |-> sck [*8] ##1 !sck; endproperty
  a_sck_phase: assert property (p_sck_phase)
    else $error("serial clock high phase wrong length");
  property p_cs_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select gap too short");
  property p_si_hold; sck && $past(sck) |-> $stable(si); endproperty
  a_si_hold: assert property (p_si_hold)
    else $error("serial input moved while clock high");
  property p_oe_release; $rose(cs_n) |-> ##[1:4] !so_oe; endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("output not released after deselect");
  property p_oe_idle; cs_n [*5] |-> !so_oe; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  property p_oe_sel; so_oe && !cs_n |-> rise_cnt_r >= 6'h08; endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("output driven before opcode complete");
  property p_so_hold; $rose(sck) && so_oe |-> ##4 $stable(so) [*4]; endproperty
  a_so_hold: assert property (p_so_hold)
    else $error("serial output moved while clock high");
  c_status: cover property ($rose(so_oe));
  c_page_frame: cover property ($rose(cs_n) && rise_cnt_r == 6'h20);
  c_wrap: cover property (so_oe && rise_cnt_r == 6'h19);
endmodule : flash_page_link_assertions

// [sim/serial_flash_page_buffer_ops_tb.sv]
// Testbench joining host and device ends over the serial link.
module serial_flash_page_buffer_ops_tb
  import flash_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic page_bin = 1'b0;
  logic prot = 1'b0;
  logic [4:0] st2 = 5'h0;
  logic op_start;
  op_kind_t op_kind;
  logic op_buf;
  logic [PAGE_W-1:0] op_page;
  logic op_done = 1'b0;
  logic mism = 1'b0;
  logic ready;
  logic sck_q = 1'b0;
  logic [31:0] si_sr = 32'h0;
  logic [15:0] so_sr = 16'h0;
  logic [31:0] stat;
  logic [14:0] starts[$];
  int dly = 20;
  int pend = 0;
  int cyc = 0;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] ops[6] = '{OP_XFER_B1, OP_XFER_B2, OP_COMP_B1, OP_COMP_B2, OP_RWR_B1, OP_RWR_B2};
  logic [1:0] kinds[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
  logic bufs[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  flash_link_if lk ();
  flash_page_host flash_page_host_inst (.SYS_CLK(clk), .SYS_RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .LINK(lk.host));
  flash_page_dev flash_page_dev_inst (.SYS_CLK(clk), .SYS_RST(rst), .LINK(lk.dev),
    .PAGE_BINARY(page_bin), .PROTECT_ON(prot), .ERASE_PROGRAM_FAIL(st2[4]),
    .LOCKDOWN_CMD_ENABLED(st2[3]), .BUF_ONE_PROG_SUSPENDED(st2[1]),
    .BUF_TWO_PROG_SUSPENDED(st2[2]), .ERASE_SUSPENDED(st2[0]), .OP_START(op_start),
    .OP_KIND(op_kind), .OP_BUF(op_buf), .OP_PAGE(op_page), .OP_DONE(op_done),
    .OP_MISMATCH(mism), .READY(ready));
  flash_page_link_assertions flash_page_link_assertions_inst (.SYS_CLK(clk), .SYS_RST(rst),
    .cs_n(lk.cs_n), .sck(lk.sck), .si(lk.si), .so(lk.so), .so_oe(lk.so_oe));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // -------------------------------------------------------------
  // Array stand-in and link monitor.
  // -------------------------------------------------------------
  always @(posedge clk) begin
    op_done <= (pend == 1) && !op_start;
    if (op_start) begin
      starts.push_back({op_kind, op_buf, op_page});
      pend <= dly;
    end else if (pend != 0) begin
      pend <= pend - 1;
    end
  end
  always @(posedge clk) begin
    sck_q <= lk.sck;
    if (!lk.cs_n && lk.sck && !sck_q) begin
      si_sr <= {si_sr[30:0], lk.si};
      so_sr <= {so_sr[14:0], lk.so};
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  // -------------------------------------------------------------
  // Tasks.
  // -------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk iff hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk iff hreadyout);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  // Issues a control word and waits until the host has finished the frame.
  task automatic cmd(input logic [31:0] c);
    logic [31:0] q;
    bus(1'b1, REG_CTRL, c, q);
    do bus(1'b0, REG_STAT, 32'h0, q); while (q[0] !== 1'b0);
    stat = q;
  endtask : cmd
  // -------------------------------------------------------------
  // Main sequence.
  // -------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [11:0] pg;
    logic [23:0] ad;
    logic [7:0] b1;
    logic [7:0] b2;
    logic comp;
    comp = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, ready}, 32'h1);
    bus(1'b0, 8'h0c, 32'h0, q);
    chk(q, 32'h0);
    for (int pb = 0; pb < 2; pb++) begin
      for (int i = 0; i < 6; i++) begin
        pg = {pb[0] ^ i[0], 3'(i), 8'hc5};
        ad = pb[0] ? {3'h7, pg, 9'h1ff} : {2'h3, pg, 10'h3ff};
        page_bin <= pb[0];
        prot <= i[0];
        st2 <= 5'(i * 7 + pb);
        mism <= (i == 3);
        bus(1'b1, REG_ADDR, {8'h0, ad}, q);
        cmd({24'h0, ops[i]});
        chk(si_sr, {ops[i], ad});
        cmd(32'h1d7);
        chk({31'h0, stat[15]}, 32'h1);
        chk(32'(starts.pop_front()), {17'h0, kinds[i], bufs[i], pg});
        if (i >= 4) begin
          chk(32'(starts.pop_front()), {17'h0, 2'h2, bufs[i], pg});
        end
        if (i == 2 || i == 3) begin
          comp = (i == 3);
        end
        cmd(32'hd7);
        b1 = {1'b1, comp, DENSITY_CODE, i[0], pb[0]};
        b2 = {1'b1, 1'b0, st2[4], 1'b0, st2[3:0]};
        chk({16'h0, stat[23:8]}, {16'h0, b1, b2});
        chk({16'h0, so_sr}, {16'h0, b1, b2});
      end
    end
    dly = 3000;
    cmd(32'h53);
    cmd(32'hd7);
    chk({16'h0, stat[23:8]} & 32'h8080, 32'h0);
    cmd(32'h60);
    cmd(32'h1d7);
    chk({31'h0, stat[15]}, 32'h1);
    chk(32'(starts.size()), 32'h1);
    end_sim();
  end
endmodule : serial_flash_page_buffer_ops_tb
